// File: hdl/adcc_top.sv
/*
  Conversion control: control, clock setting and result registers on the
  controller's data memory bus, start handshake, channel and port line setup.
  Assumes a single-cycle byte bus on mclk and an analog core that returns a
  10-bit sample on sample_data, latched when the block pulses conv_sample.
*/
// Operation
// - Start pulse low-high-low; convert on falling edge
// - Rising start resets converter, sets done flag
// - Done flag bit 6 cleared on completion
// - Bits 2:0 select one of eight channels
// - Bits 5:3 configure port lines analog/digital
// - Analog lines lose digital, pull-high; converter on
// - All configuration bits zero powers converter off
// - Init pulse within ten cycles after change; the block pulses conv_reset only on a rising start
// - Ten-bit result in two read-only registers
// - High holds 9:2; low holds 1:0 at 7:6
`default_nettype none
module adcc_top #(
  parameter logic [4:0] CONV_CLOCKS = adcc_pkg::CONV_CLOCKS
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] bus_addr,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [7:0] bus_wdata,
  output logic [7:0] bus_rdata,
  input wire logic [9:0] sample_data,
  output logic [2:0] chan_sel,
  output logic [7:0] analog_line_en,
  output logic [7:0] pull_high_dis,
  output logic conv_power_on,
  output logic conv_reset,
  output logic conv_sample,
  output logic test_mode
);
  logic [2:0] chan_q;
  logic [2:0] pcfg_q;
  logic start_q;
  logic done_flag_n_q;
  logic [1:0] clksel_q;
  logic test_q;
  logic [9:0] result_q;
  logic [4:0] conv_cnt_q;
  logic conv_tick;
  adcc_pkg::adcc_state_t state_q;
  logic wr_ctl;
  logic start_d;
  logic start_rise;
  logic start_fall;

  function automatic logic [7:0] line_map(input logic [2:0] k);
    if (k == 3'h7) begin
      line_map = 8'hFF;
    end else begin
      line_map = 8'((9'h001 << k) - 9'h001);
    end
  endfunction

  assign wr_ctl = bus_wr && (bus_addr == adcc_pkg::ADDR_CONTROL);
  assign start_d = wr_ctl ? bus_wdata[adcc_pkg::CTL_START_BIT] : start_q;
  assign start_rise = !start_q && start_d;
  assign start_fall = start_q && !start_d;

  always_ff @(posedge mclk) begin
    if (rst) begin
      chan_q <= 3'h0;
      pcfg_q <= 3'h0;
      start_q <= 1'b0;
    end else if (wr_ctl) begin
      chan_q <= bus_wdata[adcc_pkg::CTL_CHAN_LSB +: 3];
      pcfg_q <= bus_wdata[adcc_pkg::CTL_PCFG_LSB +: 3];
      start_q <= start_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      clksel_q <= adcc_pkg::CLOCK_SETTING_RESET[1:0];
      test_q <= 1'b0;
    end else if (bus_wr && bus_addr == adcc_pkg::ADDR_CLOCK_SETTING) begin
      clksel_q <= bus_wdata[1:0];
      test_q <= bus_wdata[adcc_pkg::CLK_TEST_BIT];
    end
  end

  adcc_clkdiv u_div (
    .mclk(mclk),
    .rst(rst),
    .run(state_q == adcc_pkg::ADCC_BUSY),
    .sel(clksel_q),
    .tick(conv_tick)
  );

  // Start handshake: rise resets and arms, fall begins conversion
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q <= adcc_pkg::ADCC_IDLE;
      conv_cnt_q <= 5'h00;
      done_flag_n_q <= adcc_pkg::CONTROL_RESET[adcc_pkg::CTL_DONE_BIT];
      conv_reset <= 1'b0;
      conv_sample <= 1'b0;
      result_q <= adcc_pkg::RESULT_RESET;
    end else begin
      conv_reset <= 1'b0;
      conv_sample <= 1'b0;
      if (start_rise) begin
        state_q <= adcc_pkg::ADCC_ARMED;
        done_flag_n_q <= 1'b1;
        conv_reset <= 1'b1;
        conv_cnt_q <= 5'h00;
      end else begin
        case (state_q)
          adcc_pkg::ADCC_IDLE: state_q <= adcc_pkg::ADCC_IDLE;
          adcc_pkg::ADCC_ARMED: begin
            if (start_fall) begin
              state_q <= adcc_pkg::ADCC_BUSY;
            end
          end
          adcc_pkg::ADCC_BUSY: begin
            if (conv_tick) begin
              if (conv_cnt_q == CONV_CLOCKS - 5'h01) begin
                state_q <= adcc_pkg::ADCC_IDLE;
                conv_sample <= 1'b1;
                result_q <= sample_data;
                done_flag_n_q <= 1'b0;
              end else begin
                conv_cnt_q <= conv_cnt_q + 5'h01;
              end
            end
          end
          default: state_q <= adcc_pkg::ADCC_IDLE;
        endcase
      end
    end
  end

  // Line setup; all-zero configuration powers the converter down
  always_ff @(posedge mclk) begin
    if (rst) begin
      chan_sel <= 3'h0;
      analog_line_en <= 8'h00;
      pull_high_dis <= 8'h00;
      conv_power_on <= 1'b0;
      test_mode <= 1'b0;
    end else begin
      chan_sel <= chan_q;
      analog_line_en <= line_map(pcfg_q);
      pull_high_dis <= line_map(pcfg_q);
      conv_power_on <= (pcfg_q != 3'h0);
      test_mode <= test_q;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      bus_rdata <= 8'h00;
    end else if (bus_rd) begin
      case (bus_addr)
        adcc_pkg::ADDR_RESULT_LOW: bus_rdata <= {result_q[1:0], 6'h00};
        adcc_pkg::ADDR_RESULT_HIGH: bus_rdata <= result_q[9:2];
        adcc_pkg::ADDR_CONTROL: bus_rdata <= {start_q, done_flag_n_q, pcfg_q, chan_q};
        adcc_pkg::ADDR_CLOCK_SETTING: bus_rdata <= {test_q, 5'h00, clksel_q};
        default: bus_rdata <= 8'h00;
      endcase
    end
  end

  // Start handshake and completion flag
  sequence s_rise;
    bus_wr && bus_addr == adcc_pkg::ADDR_CONTROL && !start_q && bus_wdata[7];
  endsequence

  sequence s_div8_quiet;
    (!conv_tick || clksel_q != adcc_pkg::CLKSEL_DIV8) [*7];
  endsequence

  chk_rise_sets_flag: assert property (@(posedge mclk) disable iff (rst)
    s_rise |=> done_flag_n_q && conv_reset)
    else $error("start rise did not set flag");

  chk_rise_arms: assert property (@(posedge mclk) disable iff (rst)
    s_rise |=> state_q == adcc_pkg::ADCC_ARMED)
    else $error("start rise did not arm the converter");

  chk_reset_pulse: assert property (@(posedge mclk) disable iff (rst)
    conv_reset |=> !conv_reset)
    else $error("converter reset longer than one cycle");

  chk_fall_starts: assert property (@(posedge mclk) disable iff (rst)
    (state_q == adcc_pkg::ADCC_ARMED && wr_ctl && !bus_wdata[7] && start_q)
    |=> state_q == adcc_pkg::ADCC_BUSY)
    else $error("falling start did not begin conversion");

  chk_armed_wait: assert property (@(posedge mclk) disable iff (rst)
    state_q == adcc_pkg::ADCC_ARMED && !wr_ctl |=> state_q == adcc_pkg::ADCC_ARMED)
    else $error("armed state left without a control write");

  chk_done_clears: assert property (@(posedge mclk) disable iff (rst)
    conv_sample |-> !done_flag_n_q && state_q == adcc_pkg::ADCC_IDLE)
    else $error("done flag not cleared at completion");

  chk_busy_flag: assert property (@(posedge mclk) disable iff (rst)
    state_q == adcc_pkg::ADCC_BUSY |-> done_flag_n_q)
    else $error("flag low during conversion");

  chk_busy_holds: assert property (@(posedge mclk) disable iff (rst)
    state_q == adcc_pkg::ADCC_BUSY && !conv_tick && !start_rise
    |=> state_q == adcc_pkg::ADCC_BUSY)
    else $error("conversion ended without a clock tick");

  chk_done_stays: assert property (@(posedge mclk) disable iff (rst)
    !done_flag_n_q && !start_rise |=> !done_flag_n_q)
    else $error("done flag rose without a start");

  chk_sample_pulse: assert property (@(posedge mclk) disable iff (rst)
    conv_sample |=> !conv_sample)
    else $error("sample pulse longer than one cycle");

  chk_count_bound: assert property (@(posedge mclk) disable iff (rst)
    state_q == adcc_pkg::ADCC_BUSY |-> conv_cnt_q < CONV_CLOCKS)
    else $error("conversion count past its length");

  // Conversion clock
  chk_sel_store: assert property (@(posedge mclk) disable iff (rst)
    bus_wr && bus_addr == adcc_pkg::ADDR_CLOCK_SETTING
    |=> clksel_q == $past(bus_wdata[1:0]))
    else $error("clock select not stored");

  chk_tick_single: assert property (@(posedge mclk) disable iff (rst)
    conv_tick |=> !conv_tick)
    else $error("conversion tick longer than one cycle");

  chk_div8_gap: assert property (@(posedge mclk) disable iff (rst)
    conv_tick && clksel_q == adcc_pkg::CLKSEL_DIV8 |=> s_div8_quiet)
    else $error("divide by eight tick too early");

  chk_div2_rate: assert property (@(posedge mclk) disable iff (rst)
    conv_tick && clksel_q == adcc_pkg::CLKSEL_DIV2 && state_q == adcc_pkg::ADCC_BUSY
    |-> ##2 (conv_tick || state_q != adcc_pkg::ADCC_BUSY
    || clksel_q != adcc_pkg::CLKSEL_DIV2))
    else $error("divide by two tick missing");

  // Configuration, lines and read-back
  chk_chan_write: assert property (@(posedge mclk) disable iff (rst)
    wr_ctl |=> chan_q == $past(bus_wdata[adcc_pkg::CTL_CHAN_LSB +: 3]))
    else $error("channel field not stored");

  chk_chan_route: assert property (@(posedge mclk) disable iff (rst)
    1'b1 |=> chan_sel == $past(chan_q))
    else $error("channel select not routed");

  chk_pcfg_write: assert property (@(posedge mclk) disable iff (rst)
    wr_ctl |=> pcfg_q == $past(bus_wdata[adcc_pkg::CTL_PCFG_LSB +: 3]))
    else $error("port configuration not stored");

  chk_power_off: assert property (@(posedge mclk) disable iff (rst)
    pcfg_q == 3'h0 |=> !conv_power_on)
    else $error("converter powered with no analog lines");

  chk_power_on: assert property (@(posedge mclk) disable iff (rst)
    pcfg_q != 3'h0 |=> conv_power_on)
    else $error("converter off with analog lines");

  chk_line_map: assert property (@(posedge mclk) disable iff (rst)
    pcfg_q == 3'h7 |=> analog_line_en == 8'hFF && pull_high_dis == 8'hFF)
    else $error("all lines not analog at config seven");

  chk_line_one: assert property (@(posedge mclk) disable iff (rst)
    pcfg_q == 3'h1 |=> analog_line_en == 8'h01 && pull_high_dis == 8'h01)
    else $error("lowest line not alone at config one");

  chk_line_three: assert property (@(posedge mclk) disable iff (rst)
    pcfg_q == 3'h3 |=> analog_line_en == 8'h07 && pull_high_dis == 8'h07)
    else $error("three lowest lines not analog at config three");

  chk_clk_zero: assert property (@(posedge mclk) disable iff (rst)
    bus_rd && bus_addr == adcc_pkg::ADDR_CLOCK_SETTING |=> bus_rdata[6:2] == 5'h00)
    else $error("unused clock bits not zero");

  chk_sel_read: assert property (@(posedge mclk) disable iff (rst)
    bus_rd && bus_addr == adcc_pkg::ADDR_CLOCK_SETTING
    |=> bus_rdata[1:0] == $past(clksel_q))
    else $error("clock select read back wrong");

  chk_flag_read: assert property (@(posedge mclk) disable iff (rst)
    bus_rd && bus_addr == adcc_pkg::ADDR_CONTROL
    |=> bus_rdata[adcc_pkg::CTL_DONE_BIT] == $past(done_flag_n_q))
    else $error("done flag read back wrong");

  chk_result_high: assert property (@(posedge mclk) disable iff (rst)
    bus_rd && bus_addr == adcc_pkg::ADDR_RESULT_HIGH |=> bus_rdata == $past(result_q[9:2]))
    else $error("high result byte wrong");

  chk_result_low: assert property (@(posedge mclk) disable iff (rst)
    bus_rd && bus_addr == adcc_pkg::ADDR_RESULT_LOW
    |=> bus_rdata == {$past(result_q[1:0]), 6'h00})
    else $error("low result byte wrong");

  chk_result_hold: assert property (@(posedge mclk) disable iff (rst)
    !conv_tick |=> $stable(result_q))
    else $error("result changed outside completion");
endmodule
`default_nettype wire

// File: hdl/adcc_pkg.sv
/*
  Constants for the conversion control block: register offsets, field positions,
  reset values and clock divider settings.
  Assumes a byte-wide data memory bus inside the controller core.
*/
`default_nettype none
package adcc_pkg;
  localparam logic [7:0] ADDR_RESULT_LOW = 8'h24;
  localparam logic [7:0] ADDR_RESULT_HIGH = 8'h25;
  localparam logic [7:0] ADDR_CONTROL = 8'h26;
  localparam logic [7:0] ADDR_CLOCK_SETTING = 8'h27;
  localparam int CTL_CHAN_LSB = 0;
  localparam int CTL_PCFG_LSB = 3;
  localparam int CTL_DONE_BIT = 6;
  localparam int CTL_START_BIT = 7;
  localparam int CLK_TEST_BIT = 7;
  localparam logic [7:0] CONTROL_RESET = 8'h40;
  localparam logic [7:0] CLOCK_SETTING_RESET = 8'h00;
  localparam logic [1:0] CLKSEL_DIV2 = 2'h0;
  localparam logic [1:0] CLKSEL_DIV8 = 2'h1;
  localparam logic [1:0] CLKSEL_DIV32 = 2'h2;
  localparam logic [4:0] HALF_DIV2 = 5'h00;
  localparam logic [4:0] HALF_DIV8 = 5'h03;
  localparam logic [4:0] HALF_DIV32 = 5'h0F;
  localparam logic [4:0] CONV_CLOCKS = 5'h10;
  localparam logic [9:0] RESULT_RESET = 10'h000;
  typedef enum logic [1:0] {ADCC_IDLE, ADCC_ARMED, ADCC_BUSY} adcc_state_t;
endpackage
`default_nettype wire

// File: hdl/adcc_clkdiv.sv
/*
  Conversion clock divider: produces a one-cycle tick at the selected rate.
  Assumes the select comes from the clock setting register in the same domain.
*/
`default_nettype none
module adcc_clkdiv (
  input wire logic mclk,
  input wire logic rst,
  input wire logic run,
  input wire logic [1:0] sel,
  output logic tick
);
  logic [4:0] cnt_q;
  logic [4:0] half;
  logic phase_q;

  always_comb begin
    case (sel)
      adcc_pkg::CLKSEL_DIV2: half = adcc_pkg::HALF_DIV2;
      adcc_pkg::CLKSEL_DIV8: half = adcc_pkg::HALF_DIV8;
      adcc_pkg::CLKSEL_DIV32: half = adcc_pkg::HALF_DIV32;
      default: half = adcc_pkg::HALF_DIV32;
    endcase
  end

  // Tick once per full divided period (two halves)
  always_ff @(posedge mclk) begin
    if (rst || !run) begin
      cnt_q <= 5'h00;
      phase_q <= 1'b0;
      tick <= 1'b0;
    end else if (cnt_q >= half) begin
      cnt_q <= 5'h00;
      phase_q <= ~phase_q;
      tick <= phase_q;
    end else begin
      cnt_q <= cnt_q + 5'h01;
      tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: verif/adcc_analog_model.sv
/*
  Analog core stand-in: returns a fixed sample for each selected channel.
  Assumes chan_sel and conv_power_on come from the conversion control block.
*/
`default_nettype none
module adcc_analog_model (
  input wire logic [2:0] chan_sel,
  input wire logic conv_power_on,
  output logic [9:0] sample_data
);
  timeunit 1ns;
  timeprecision 1ps;
  // An unpowered core gives no usable level, so show the inverse pattern
  assign sample_data = conv_power_on ? {chan_sel, 4'hA, chan_sel} : ~{chan_sel, 4'hA, chan_sel};
endmodule
`default_nettype wire

// File: verif/adcc_top_tb.sv
/*
  Self-checking bench for the conversion control block.
  Assumes the block's single-cycle byte bus and the analog core model.
*/
`default_nettype none
module adcc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic [7:0] bus_addr = 8'h00;
  logic [7:0] bus_wdata = 8'h00;
  logic [7:0] bus_rdata, rd, ctl, exp_en;
  logic [9:0] sample_data;
  logic [2:0] chan_sel;
  logic [7:0] analog_line_en, pull_high_dis;
  logic conv_power_on, conv_reset, conv_sample, test_mode;
  int errors = 0;
  int tests_run = 0;
  int cycles = 0;
  int resets = 0;
  int samples = 0;

  always #10 mclk = ~mclk;

  adcc_top #(.CONV_CLOCKS(5'h02)) u_adcc_top (.mclk(mclk), .rst(rst), .bus_addr(bus_addr),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
    .sample_data(sample_data), .chan_sel(chan_sel), .analog_line_en(analog_line_en),
    .pull_high_dis(pull_high_dis), .conv_power_on(conv_power_on), .conv_reset(conv_reset),
    .conv_sample(conv_sample), .test_mode(test_mode));
  adcc_analog_model u_adcc_analog_model (.chan_sel(chan_sel), .conv_power_on(conv_power_on),
    .sample_data(sample_data));

  task automatic test_done();
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Pulse counters and the hang guard
  always @(posedge mclk) begin
    cycles++;
    if (conv_reset === 1'b1) resets++;
    if (conv_sample === 1'b1) samples++;
    if (cycles == 20000) begin
      errors++;
      test_done();
    end
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] want);
    tests_run++;
    if (seen !== want) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, want, seen);
    end
  endtask

  task automatic bus_write(input logic [7:0] a, input logic [7:0] d);
    bus_addr = a;
    bus_wdata = d;
    bus_wr = 1'b1;
    @(posedge mclk);
    #1 bus_wr = 1'b0;
    @(posedge mclk);
    #1;
  endtask

  task automatic bus_read(input logic [7:0] a, output logic [7:0] d);
    bus_addr = a;
    bus_rd = 1'b1;
    @(posedge mclk);
    #1 bus_rd = 1'b0;
    @(posedge mclk);
    #1 d = bus_rdata;
  endtask

  task automatic convert(input logic [7:0] c, input logic [1:0] s);
    int r0;
    int s0;
    int n;
    logic [9:0] want;
    r0 = resets;
    s0 = samples;
    want = {c[2:0], 4'hA, c[2:0]};
    bus_write(8'h27, {6'h00, s});
    bus_write(8'h26, c | 8'h80);
    bus_read(8'h26, rd);
    check("flag set", rd, c | 8'hC0);
    bus_write(8'h26, c);
    bus_read(8'h26, rd);
    if (s == 2'h2) check("busy", rd, c | 8'h40);
    n = 0;
    while (rd[6] !== 1'b0 && n < 100) begin
      bus_read(8'h26, rd);
      n++;
    end
    check("flag done", rd, c);
    check("resets", 8'(resets - r0), 8'h01);
    check("samples", 8'(samples - s0), 8'h01);
    bus_read(8'h25, rd);
    check("high", rd, want[9:2]);
    bus_read(8'h24, rd);
    check("low", rd, {want[1:0], 6'h00});
  endtask

  initial begin
    repeat (6) @(posedge mclk);
    #1 rst = 1'b0;
    bus_read(8'h26, rd);
    check("control", rd, adcc_pkg::CONTROL_RESET);
    bus_read(8'h30, rd);
    check("unmapped", rd, 8'h00);
    bus_read(8'h27, rd);
    check("clock", rd, adcc_pkg::CLOCK_SETTING_RESET);
    bus_write(8'h27, 8'h7E);
    bus_read(8'h27, rd);
    check("clock unused", rd, 8'h02);
    check("test", {7'h00, test_mode}, 8'h00);
    bus_write(8'h24, 8'hFF);
    bus_read(8'h24, rd);
    check("result ro", rd, 8'h00);
    for (int k = 0; k < 8; k++) begin
      ctl = {2'b00, 3'(k), 3'(7 - k)};
      bus_write(8'h26, ctl);
      exp_en = (k == 7) ? 8'hFF : 8'((1 << k) - 1);
      check("lines", analog_line_en, exp_en);
      check("pull", pull_high_dis, exp_en);
      check("power", {7'h00, conv_power_on}, {7'h00, k != 0});
      check("chan", {5'h00, chan_sel}, {5'h00, ctl[2:0]});
      if (k != 0) convert(ctl, 2'(k % 3));
    end
    test_done();
  end
endmodule
`default_nettype wire
